// File: core/itp_defs.svh
// Register indices, field positions, reset values and vector codes of the interrupt test block
`ifndef ITP_DEFS_SVH
`define ITP_DEFS_SVH

// Register indices; byte address on the bus is four times the index
`define ITP_IDX_TEST_CTRL 8'h15
`define ITP_IDX_FORCE     8'h16
`define ITP_IDX_PROMOTE   8'h1F
`define ITP_IDX_STATUS    8'h20
`define ITP_IDX_MASK      8'h21

// Test control fields
`define ITP_TWE_BIT       4
`define ITP_GRP_MSB       3

// Reset values
`define ITP_TEST_CTRL_RST 5'h00
`define ITP_PROMOTE_RST   7'h00
`define ITP_EVT_RST       3'h0

// Request index = vector low byte / 2
`define ITP_IDX_POR       7'h7F
`define ITP_IDX_OSCMON    7'h7E
`define ITP_IDX_WDOG      7'h7D
`define ITP_IDX_TRAP      7'h7C
`define ITP_IDX_SWTRAP    7'h7B
`define ITP_IDX_NMIPIN    7'h7A
`define ITP_IDX_MASKPIN   7'h79
`define ITP_TOP_GROUP     4'hF
`define ITP_TOP_GRP_MASK  8'h07

// Implemented test groups, one bit per group
`define ITP_IMPL_GROUPS   16'hFFFF

// Status event bits
`define ITP_EVT_VEC       0
`define ITP_EVT_WAKE      1
`define ITP_EVT_BLOCKED   2

`endif

// File: core/itp_pkg.sv
// Types shared by the interrupt test and priority promotion block
package itp_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [9:0]  paddr;
    logic [31:0] pwdata;
  } itp_apb_t;

  typedef struct packed {
    logic [4:0]   irqTestControl;
    logic [127:0] forceBank;
    logic [6:0]   promotedIrqSelect;
    logic [7:0]   vecOut;
    logic         vecValid;
    logic [7:0]   lastVec;
    logic [2:0]   status;
    logic [2:0]   mask;
    logic [31:0]  prdata;
    logic [1:0]   maskPinSync;
    logic [1:0]   nmiPinSync;
  } itp_state_t;

endpackage

// File: core/itp_core.sv
// Interrupt test registers, priority promotion, vector priority and wake-up
//
// Function
// - Special mode test read gives live inputs, or forced values when write enable set.
// - Normal mode test register reads always return zero.
// - Test writes need special mode, write enable and maskable mask set.
// - Each test bit forces one vector; bit n maps to vector low byte 2n.
// - In test mode real request lines are replaced by test register contents; the wake path (wakeup, wake event) still follows the live pins and periphReq.
// - One test register per eight vectors, all at one address, chosen by select.
// - Group 0xF exposes only bits 2:0; bits 7:3 read zero.
// - Unimplemented group: writes ignored, reads zero.
// - Promotion register readable always, writable only with maskable mask set.
// - Promotion bits 7:1 pick a maskable vector raised to top maskable priority.
// - Invalid or out-of-range promotion leaves maskable pin as top maskable.
// - Asynchronous wake-up on any valid interrupt while the maskable mask is clear, or on a nonmaskable pin request.
// - System decodes reset cause; block supplies matching reset vector.
// - Priority decoder checks validity of pending requests and ranks them.
// - Test control bit 4 is test write enable; disconnects inputs when set in special mode; the wake path stays on the live inputs.
// - Group select equals upper nibble of the vector low byte.
// - Active promoted interrupt goes to decoder ahead of other maskables.
// - Fixed order: resets, trap, software trap, nonmaskable pin, maskable pin, sources.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "itp_defs.svh"

module itp_core
  import itp_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire itp_apb_t     apbReq,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         specialMode,
  input  wire logic         iMask,
  input  wire logic         xMask,
  input  wire logic [120:0] periphReq,
  input  wire logic         maskPinRequest_n,
  input  wire logic         nonmaskablePinRequest_n,
  input  wire logic         powerOnReq,
  input  wire logic         oscMonitorReq,
  input  wire logic         watchdogReset,
  input  wire logic         unimplTrap,
  input  wire logic         softwareTrap,
  input  wire logic         vecReq,
  output logic [7:0]        vecOut,
  output logic              vecValid,
  output logic              wakeup,
  output logic              irqOut
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Accessible bits of one test group
  function automatic logic [7:0] groupMask(input logic [3:0] g);
    logic [15:0] impl;
    impl = `ITP_IMPL_GROUPS;
    if (!impl[g]) begin
      groupMask = 8'h00;
    end else if (g == `ITP_TOP_GROUP) begin
      groupMask = `ITP_TOP_GRP_MASK;
    end else begin
      groupMask = 8'hFF;
    end
  endfunction

  // True where a request index falls on an accessible test bit
  function automatic logic bitAccessible(input logic [6:0] idx);
    logic [7:0] m;
    m = groupMask(idx[6:3]);
    bitAccessible = m[idx[2:0]];
  endfunction

  // Highest requesting device source (highest vector wins)
  function automatic logic [6:0] topSource(input logic [120:0] v);
    topSource = 7'h00;
    for (int i = 0; i < 121; i++) begin
      if (v[i]) begin
        topSource = 7'(i);
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State and decode

  itp_state_t state_reg;
  itp_state_t state_next;

  logic         setupRd;
  logic         access;
  logic [7:0]   regIdx;
  logic         hit;
  logic [3:0]   grp;
  logic [7:0]   gMask;
  logic         testWe;
  logic         testActive;
  logic         forceWrOk;
  logic [127:0] liveReq;
  logic [127:0] effReq;
  logic [120:0] validSrc;
  logic [6:0]   promIdx;
  logic         promoOk;
  logic         promoHit;
  logic         anyReq;
  logic [7:0]   winVec;
  logic [7:0]   readVal;
  logic         wakeSeen;
  logic [2:0]   evt;

  assign regIdx     = apbReq.paddr[9:2];
  assign setupRd    = apbReq.psel && !apbReq.penable && !apbReq.pwrite;
  assign access     = apbReq.psel && apbReq.penable;
  assign hit        = (apbReq.paddr[1:0] == 2'h0)
                    && (regIdx == `ITP_IDX_TEST_CTRL || regIdx == `ITP_IDX_FORCE
                    ||  regIdx == `ITP_IDX_PROMOTE   || regIdx == `ITP_IDX_STATUS
                    ||  regIdx == `ITP_IDX_MASK);
  assign grp        = state_reg.irqTestControl[`ITP_GRP_MSB:0];
  assign gMask      = groupMask(grp);
  assign testWe     = state_reg.irqTestControl[`ITP_TWE_BIT];
  assign testActive = specialMode && testWe;
  assign forceWrOk  = specialMode && testWe && iMask;

  // Live requests; pins are active low and synchronised
  always_comb begin
    liveReq                   = '0;
    liveReq[120:0]            = periphReq;
    liveReq[`ITP_IDX_MASKPIN] = !state_reg.maskPinSync[1];
    liveReq[`ITP_IDX_NMIPIN]  = !state_reg.nmiPinSync[1];
  end

  // Test mode substitutes forced values for the request lines
  assign effReq = testActive ? state_reg.forceBank : liveReq;

  // Only implemented vectors count as valid device sources
  always_comb begin
    for (int i = 0; i < 121; i++) begin
      validSrc[i] = effReq[i] && bitAccessible(7'(i));
    end
  end

  assign promIdx  = state_reg.promotedIrqSelect;
  assign promoOk  = (promIdx < `ITP_IDX_MASKPIN)
                  && bitAccessible(promIdx);
  assign promoHit = promoOk && validSrc[promIdx];

  // Fixed priority vector selection
  always_comb begin
    anyReq = 1'b1;
    if (powerOnReq) begin
      winVec = {`ITP_IDX_POR, 1'b0};
    end else if (oscMonitorReq) begin
      winVec = {`ITP_IDX_OSCMON, 1'b0};
    end else if (watchdogReset) begin
      winVec = {`ITP_IDX_WDOG, 1'b0};
    end else if (unimplTrap) begin
      winVec = {`ITP_IDX_TRAP, 1'b0};
    end else if (softwareTrap) begin
      winVec = {`ITP_IDX_SWTRAP, 1'b0};
    end else if (effReq[`ITP_IDX_NMIPIN] && !xMask) begin
      winVec = {`ITP_IDX_NMIPIN, 1'b0};
    end else if (!iMask && promoHit) begin
      winVec = {promIdx, 1'b0};
    end else if (!iMask && effReq[`ITP_IDX_MASKPIN]) begin
      winVec = {`ITP_IDX_MASKPIN, 1'b0};
    end else if (!iMask && (|validSrc)) begin
      winVec = {topSource(validSrc), 1'b0};
    end else begin
      anyReq = 1'b0;
      winVec = state_reg.lastVec;
    end
  end

  // Test register read view
  always_comb begin
    if (!specialMode) begin
      readVal = 8'h00;
    end else if (testWe) begin
      readVal = state_reg.forceBank[{grp, 3'b000} +: 8] & gMask;
    end else begin
      readVal = liveReq[{grp, 3'b000} +: 8] & gMask;
    end
  end

  // Asynchronous wake path; works with the block clock stopped
  assign wakeup = !nonmaskablePinRequest_n
                || (!iMask && (!maskPinRequest_n || (|periphReq)));
  assign wakeSeen = !state_reg.nmiPinSync[1]
                  || (!iMask && (liveReq[`ITP_IDX_MASKPIN] || (|periphReq)));

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    state_next          = state_reg;
    evt                 = 3'h0;
    state_next.vecValid = 1'b0;
    state_next.maskPinSync = {state_reg.maskPinSync[0], maskPinRequest_n};
    state_next.nmiPinSync  = {state_reg.nmiPinSync[0], nonmaskablePinRequest_n};

    if (vecReq) begin
      state_next.vecOut   = winVec;
      state_next.vecValid = 1'b1;
      evt[`ITP_EVT_VEC]   = 1'b1;
      if (anyReq) begin
        state_next.lastVec = winVec;
      end
    end
    evt[`ITP_EVT_WAKE] = wakeSeen;

    if (setupRd) begin
      case (regIdx)
        `ITP_IDX_TEST_CTRL: state_next.prdata = {27'h0, state_reg.irqTestControl};
        `ITP_IDX_FORCE:     state_next.prdata = {24'h0, readVal};
        `ITP_IDX_PROMOTE:   state_next.prdata = {24'h0, promIdx, 1'b0};
        `ITP_IDX_STATUS:    state_next.prdata = {29'h0, state_reg.status};
        `ITP_IDX_MASK:      state_next.prdata = {29'h0, state_reg.mask};
        default:            state_next.prdata = 32'h0000_0000;
      endcase
      if (!hit) begin
        state_next.prdata = 32'h0000_0000;
      end
    end

    if (access && apbReq.pwrite && hit) begin
      case (regIdx)
        `ITP_IDX_TEST_CTRL: begin
          state_next.irqTestControl[`ITP_GRP_MSB:0] = apbReq.pwdata[`ITP_GRP_MSB:0];
          if (specialMode && iMask && xMask) begin
            state_next.irqTestControl[`ITP_TWE_BIT] = apbReq.pwdata[`ITP_TWE_BIT];
          end
        end
        `ITP_IDX_FORCE: begin
          if (forceWrOk) begin
            state_next.forceBank[{grp, 3'b000} +: 8] =
              (state_reg.forceBank[{grp, 3'b000} +: 8] & ~gMask)
              | (apbReq.pwdata[7:0] & gMask);
          end else begin
            evt[`ITP_EVT_BLOCKED] = 1'b1;
          end
        end
        `ITP_IDX_PROMOTE: begin
          if (iMask) begin
            state_next.promotedIrqSelect = apbReq.pwdata[7:1];
          end
        end
        `ITP_IDX_STATUS: state_next.status = state_reg.status & ~apbReq.pwdata[2:0];
        `ITP_IDX_MASK:   state_next.mask = apbReq.pwdata[2:0];
        default: ;
      endcase
    end
    // A new event wins over a simultaneous clear
    state_next.status = state_next.status | evt;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg                   <= '0;
      state_reg.irqTestControl    <= `ITP_TEST_CTRL_RST;
      state_reg.promotedIrqSelect <= `ITP_PROMOTE_RST;
      state_reg.lastVec           <= {`ITP_IDX_SWTRAP, 1'b0};
      state_reg.status            <= `ITP_EVT_RST;
      state_reg.maskPinSync       <= 2'h3;
      state_reg.nmiPinSync        <= 2'h3;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata   = state_reg.prdata;
  assign pready   = 1'b1;
  assign pslverr  = access && !hit;
  assign vecOut   = state_reg.vecOut;
  assign vecValid = state_reg.vecValid;
  assign irqOut   = |(state_reg.status & state_reg.mask);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  logic fixedAny;
  assign fixedAny = powerOnReq || oscMonitorReq || watchdogReset || unimplTrap || softwareTrap;

  a_normal_read_zero: assert property (setupRd && regIdx == `ITP_IDX_FORCE && !specialMode
      |=> prdata == 32'h0000_0000) else $error("test read not zero in normal mode");

  a_live_read_view: assert property (setupRd && regIdx == `ITP_IDX_FORCE && specialMode
      && !testWe |=> prdata[7:0] == ($past(liveReq[{grp, 3'b000} +: 8]) & $past(gMask)))
    else $error("test read does not show live inputs");

  a_force_write_gate: assert property (access && apbReq.pwrite && regIdx == `ITP_IDX_FORCE
      && !forceWrOk |=> $stable(state_reg.forceBank))
    else $error("test write accepted while gated");

  a_top_group_bits: assert property (state_reg.forceBank[127:123] == 5'h00)
    else $error("forcing above nonmaskable pin vector");

  a_promo_write_gate: assert property (access && apbReq.pwrite
      && regIdx == `ITP_IDX_PROMOTE && !iMask |=> $stable(state_reg.promotedIrqSelect))
    else $error("promotion written with mask clear");

  a_reset_vector_first: assert property (vecReq && powerOnReq
      |=> vecValid && vecOut == 8'hFE) else $error("power-on vector not first");

  a_promo_first: assert property (vecReq && !iMask && promoHit && !powerOnReq
      && !oscMonitorReq && !watchdogReset && !unimplTrap && !softwareTrap
      && !(effReq[`ITP_IDX_NMIPIN] && !xMask)
      |=> vecOut == {$past(promIdx), 1'b0}) else $error("promoted vector not chosen");

  a_nmi_wakeup: assert property (!nonmaskablePinRequest_n |-> wakeup)
    else $error("no wake-up on nonmaskable pin");

  a_vec_answer: assert property (vecReq
      |=> vecValid)
    else $error("no vector answer after request");

  a_vec_single: assert property (!vecReq
      |=> !vecValid)
    else $error("vector answer without request");

  a_osc_vector: assert property (vecReq && !powerOnReq
      && oscMonitorReq |=> vecOut == 8'hFC)
    else $error("oscillator monitor vector wrong");

  a_wdog_vector: assert property (vecReq && !powerOnReq && !oscMonitorReq
      && watchdogReset |=> vecOut == 8'hFA)
    else $error("watchdog reset vector wrong");

  a_trap_vector: assert property (vecReq && !powerOnReq && !oscMonitorReq
      && !watchdogReset && unimplTrap |=> vecOut == 8'hF8)
    else $error("trap vector wrong");

  a_swtrap_vector: assert property (vecReq && !powerOnReq && !oscMonitorReq
      && !watchdogReset && !unimplTrap && softwareTrap |=> vecOut == 8'hF6)
    else $error("software trap vector wrong");

  a_nmi_vector: assert property (vecReq && !fixedAny && !xMask
      && effReq[`ITP_IDX_NMIPIN] |=> vecOut == 8'hF4)
    else $error("nonmaskable pin vector wrong");

  a_mask_pin_vector: assert property (vecReq && !fixedAny && !iMask && !promoHit
      && !(effReq[`ITP_IDX_NMIPIN] && !xMask) && effReq[`ITP_IDX_MASKPIN]
      |=> vecOut == 8'hF2) else $error("maskable pin vector wrong");

  a_masked_keeps_last: assert property (vecReq && !fixedAny && iMask
      && !(effReq[`ITP_IDX_NMIPIN] && !xMask) |=> vecOut == $past(state_reg.lastVec))
    else $error("masked request did not repeat last vector");

  a_enable_write_gate: assert property (access && apbReq.pwrite
      && regIdx == `ITP_IDX_TEST_CTRL && !(specialMode && iMask && xMask)
      |=> $stable(testWe)) else $error("test write enable changed while gated");

  a_test_mode_swap: assert property (vecReq && testActive && !fixedAny && xMask && !iMask
      && !promoHit && state_reg.forceBank[`ITP_IDX_MASKPIN] |=> vecOut == 8'hF2)
    else $error("forced maskable pin not used in test mode");

  a_wake_mask_pin: assert property (!iMask && !maskPinRequest_n
      |-> wakeup)
    else $error("no wake-up on maskable pin");

  a_promo_readback: assert property (setupRd && regIdx == `ITP_IDX_PROMOTE && hit
      |=> prdata == {24'h0, $past(promIdx), 1'b0})
    else $error("promotion register read back wrong");

  a_event_set_wins: assert property (vecReq && access && apbReq.pwrite
      && regIdx == `ITP_IDX_STATUS && apbReq.pwdata[0]
      |=> state_reg.status[`ITP_EVT_VEC]) else $error("event lost under clear");

endmodule
`default_nettype wire

// File: test/itp_cpu_model.sv
// Behavioural CPU core that asks the interrupt block for vectors
`timescale 1ns/1ps
`default_nettype none
module itp_cpu_model
  import itp_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       go,
  input  wire logic [3:0] stall,
  input  wire logic       vecValid,
  input  wire logic [7:0] vecOut,
  output logic            vecReq,
  output logic [7:0]      got,
  output logic            done
);
  // Optional stall, one-cycle request, answer taken one cycle later
  initial begin
    vecReq = 1'b0;
    done = 1'b0;
    got = 8'h00;
    forever begin
      @(posedge clock);
      if (go === 1'b1) begin
        repeat (stall) @(posedge clock);
        vecReq <= 1'b1;
        @(posedge clock);
        vecReq <= 1'b0;
        @(posedge clock);
        got <= (vecValid === 1'b1) ? vecOut : 8'hXX;
        done <= 1'b1;
        @(posedge clock);
        done <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: test/test_interrupt_test_and_priority_promotion.sv
// Self-checking bench for the interrupt test and priority promotion block
`timescale 1ns/1ps
`default_nettype none
`include "itp_defs.svh"
module test_interrupt_test_and_priority_promotion
  import itp_pkg::*;
;
  localparam logic [9:0] A_CTL = {`ITP_IDX_TEST_CTRL, 2'b00};
  localparam logic [9:0] A_FRC = {`ITP_IDX_FORCE, 2'b00};
  localparam logic [9:0] A_PRO = {`ITP_IDX_PROMOTE, 2'b00};
  localparam logic [9:0] A_STS = {`ITP_IDX_STATUS, 2'b00};
  localparam logic [9:0] A_MSK = {`ITP_IDX_MASK, 2'b00};
  logic         clock, rst_n, pready, pslverr, specialMode, iMask, xMask;
  itp_apb_t     apbReq;
  logic [31:0]  prdata, rdat;
  logic [120:0] periphReq;
  logic         maskPinRequest_n, nonmaskablePinRequest_n, lastErr;
  logic         powerOnReq, oscMonitorReq, watchdogReset, unimplTrap, softwareTrap;
  logic         vecReq, vecValid, wakeup, irqOut, go, done;
  logic [7:0]   vecOut, got, lastV;
  logic [3:0]   stall;
  logic [127:0] mdl;
  int           failCount, checksDone;

  itp_core i_dut (.clock, .rst_n, .apbReq, .prdata, .pready, .pslverr, .specialMode, .iMask,
    .xMask, .periphReq, .maskPinRequest_n, .nonmaskablePinRequest_n, .powerOnReq,
    .oscMonitorReq, .watchdogReset, .unimplTrap, .softwareTrap, .vecReq, .vecOut, .vecValid,
    .wakeup, .irqOut);
  itp_cpu_model i_cpu (.clock, .go, .stall, .vecValid, .vecOut, .vecReq, .got, .done);

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checksDone++;
    if (s !== e) begin
      failCount++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clock);
    apbReq.penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rdat = prdata;
    lastErr = pslverr;
    apbReq <= '0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  // Reference priority: fixed sources, then the promoted one, then descending index
  function automatic logic [7:0] expv(input logic [127:0] r, input int pr);
    for (int i = 127; i >= 0; i--)
      if (r[i]) return (i <= 121 && pr < 121 && r[pr]) ? 8'(pr * 2) : 8'(i * 2);
    return lastV;
  endfunction
  task automatic vec(input logic [7:0] e);
    stall <= 4'($urandom);
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    repeat (40) begin
      @(posedge clock);
      if (done === 1'b1) break;
    end
    chk({31'h0, done}, 32'h1);
    chk({24'h0, got}, {24'h0, e});
    lastV = e;
  endtask
  task automatic drive();
    maskPinRequest_n <= !mdl[121];
    nonmaskablePinRequest_n <= !mdl[122];
    {powerOnReq, oscMonitorReq, watchdogReset, unimplTrap, softwareTrap} <= mdl[127:123];
    periphReq <= mdl[120:0];
    repeat (4) @(posedge clock);
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    apbReq = '0;
    {specialMode, go, stall, rst_n, mdl} = '0;
    {iMask, xMask, maskPinRequest_n, nonmaskablePinRequest_n} = 4'hF;
    {periphReq, powerOnReq, oscMonitorReq, watchdogReset, unimplTrap, softwareTrap} = '0;
    lastV = 8'hF6;
    void'($urandom(82127));
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(A_CTL, 0);
    rd(A_FRC, 0);
    rd(A_PRO, 0);
    rd(A_STS, 0);
    rd(10'h010, 0);
    chk({31'h0, lastErr}, 1);
    $display("reset and map test done");
    periphReq <= 121'({$urandom, $urandom, $urandom, $urandom});
    wr(A_CTL, 3);
    rd(A_FRC, 0);
    specialMode <= 1'b1;
    for (int g = 0; g < 15; g++) begin
      wr(A_CTL, g);
      rd(A_FRC, {24'h0, periphReq[g*8+:8]});
    end
    wr(A_CTL, 15);
    rd(A_FRC, {31'h0, periphReq[120]});
    $display("live read test done");
    periphReq <= '1;
    wr(A_CTL, 32'h13);
    wr(A_FRC, 32'hFF);
    rd(A_FRC, 32'hFF);
    wr(A_CTL, 32'h1F);
    wr(A_FRC, 32'hFF);
    rd(A_FRC, 32'h07);
    wr(A_PRO, 32'h36);
    iMask <= 1'b0;
    wr(A_FRC, 0);
    rd(A_FRC, 32'h07);
    wr(A_PRO, 32'h50);
    rd(A_PRO, 32'h36);
    mdl[31:24] = 8'hFF;
    mdl[121:120] = 2'h3;
    vec(expv(mdl, 8'h36 >> 1));
    iMask <= 1'b1;
    wr(A_PRO, 32'hF4);
    iMask <= 1'b0;
    vec(expv(mdl, 8'hF4 >> 1));
    iMask <= 1'b1;
    wr(A_FRC, 0);
    iMask <= 1'b0;
    mdl[121:120] = 2'h0;
    vec(expv(mdl, 8'hF4 >> 1));
    $display("force and promotion test done");
    iMask <= 1'b1;
    wr(A_CTL, 0);
    mdl = '0;
    specialMode <= 1'b0;
    drive();
    chk({31'h0, wakeup}, 0);
    nonmaskablePinRequest_n <= 1'b0;
    @(posedge clock);
    chk({31'h0, wakeup}, 1);
    {iMask, xMask} <= 2'b00;
    mdl[31:0] = $urandom | 32'h1;
    for (int j = 120; j <= 127; j++) begin
      mdl[j] = 1'b1;
      drive();
      vec(expv(mdl, 8'hF4 >> 1));
    end
    $display("fixed priority test done");
    mdl = '0;
    {iMask, xMask} <= 2'b11;
    drive();
    wr(A_STS, 7);
    rd(A_STS, 0);
    vec(lastV);
    rd(A_STS, 1);
    chk({31'h0, irqOut}, 0);
    wr(A_MSK, 1);
    @(posedge clock);
    chk({31'h0, irqOut}, 1);
    wr(A_STS, 1);
    @(posedge clock);
    chk({31'h0, irqOut}, 0);
    $display("interrupt test done");
    conclude();
  end
  initial begin
    #200000;
    failCount++;
    conclude();
  end
endmodule
`default_nettype wire
